// ### hdl/gccs_defs.svh
// Purpose: offsets, field positions, reset values of the global config block
// Assumes: 8-bit registers on a byte-wide internal register port
// Notes: included by its bare name
`ifndef GCCS_DEFS_SVH
`define GCCS_DEFS_SVH
`define GCCS_ADDR_W 11
`define GCCS_OFF_BANK 11'h000
`define GCCS_OFF_MASTER_CONFIG_ONE 11'h009
`define GCCS_OFF_MASTER_CONFIG_TWO 11'h00a
`define GCCS_BIT_BANK 0
`define GCCS_BIT_SRST 7
`define GCCS_BIT_IC1SEL 5
`define GCCS_BIT_OSCSEL 4
`define GCCS_BIT_RING_OSC_DISABLE 3
`define GCCS_BIT_DBL 2
`define GCCS_MASTER_CONFIG_ONE_MASK 8'hbf
`define GCCS_MASTER_CONFIG_TWO_MASK 8'h77
`define GCCS_RST_BANK 1'b0
`define GCCS_RST_MASTER_CONFIG_ONE 8'h00
`define GCCS_RST_MASTER_CONFIG_TWO 8'h00
`endif

// ### hdl/gccs_pkg.sv
// Purpose: types of the global config block
// Assumes: gccs_defs.svh constants
// Notes: none
package gccs_pkg;
  typedef enum logic [2:0] {
    GCCS_CLK_RING = 3'b001,
    GCCS_CLK_OSC = 3'b010,
    GCCS_CLK_IC1 = 3'b100
  } gccs_clk_src_e;
  typedef enum logic [1:0] {
    GCCS_PIN_OFF = 2'b00,
    GCCS_PIN_XTAL = 2'b01,
    GCCS_PIN_EXT = 2'b10,
    GCCS_PIN_UNUSED = 2'b11
  } gccs_pin_mode_e;
  typedef struct packed {
    logic soft_reset;
    logic master_clock_from_input_one;
    logic master_clock_from_osc_pin;
    logic ring_osc_disable;
    logic clock_doubler_enable;
    logic [1:0] osc_pin_mode;
  } gccs_master_config_one_s;
  typedef struct packed {
    logic [1:0] ext_switch_source;
    logic auto_increment_disable;
    logic [2:0] master_clock_range;
  } gccs_master_config_two_s;
endpackage : gccs_pkg

// ### hdl/gccs_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: asynchronous source
// Notes: first stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module gccs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule : gccs_sync
`default_nettype wire

// ### hdl/gccs_global_config.sv
// Purpose: global configuration registers and master clock source control
// Assumes: serial interface logic drives a byte register port on sys_clk
// Notes: pin-strap defaults caught while reset_pin_low is asserted
`timescale 1ns/10ps
`default_nettype none
`include "gccs_defs.svh"
module gccs_global_config #(
  parameter int STRAP_W = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reset_pin_low_n,
  input wire logic [STRAP_W-1:0] strap_pins,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`GCCS_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output var logic [7:0] reg_rdata,
  output logic eeprom_bank_active,
  output logic device_in_reset,
  output logic [STRAP_W-1:0] strap_defaults,
  output gccs_pkg::gccs_clk_src_e master_clock_source,
  output logic ring_osc_power,
  output logic doubler_power,
  output logic osc_input_pin_enable,
  output logic osc_output_pin_enable,
  output logic osc_single_ended,
  output logic [1:0] ext_switch_source,
  output logic [3:0] gpio_switch_select,
  output logic auto_increment_disable,
  output logic addr_advance,
  output logic [2:0] master_clock_range
);
  logic bank_sel;
  gccs_pkg::gccs_master_config_one_s master_config_one;
  gccs_pkg::gccs_master_config_two_s master_config_two;
  logic [STRAP_W-1:0] strap_sync;
  logic pin_reset_sync_n;
  logic [STRAP_W-1:0] strap_latch;
  logic [7:0] master_config_one_byte;
  logic [7:0] master_config_two_byte;
  logic [7:0] master_config_one_wmask;
  logic [7:0] master_config_two_wmask;
  logic [7:0] next_rdata;

  gccs_sync #(.WIDTH(STRAP_W + 1)) u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({reset_pin_low_n, strap_pins}),
    .sync_out({pin_reset_sync_n, strap_sync})
  );

  // straps are sampled only by the reset pin, never by soft reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strap_latch <= '0;
    end else if (!pin_reset_sync_n) begin
      strap_latch <= strap_sync;
    end
  end
  assign strap_defaults = strap_latch;

  // bank 0 holds the global registers; address 0 stays visible in either bank
  wire in_dev_bank = !bank_sel || (reg_addr == `GCCS_OFF_BANK);
  wire hit_bank = reg_addr == `GCCS_OFF_BANK;
  wire hit_master_config_one = in_dev_bank && (reg_addr == `GCCS_OFF_MASTER_CONFIG_ONE);
  wire hit_master_config_two = in_dev_bank && (reg_addr == `GCCS_OFF_MASTER_CONFIG_TWO);
  wire soft_reset = master_config_one.soft_reset;
  assign master_config_one_wmask = `GCCS_MASTER_CONFIG_ONE_MASK;
  assign master_config_two_wmask = `GCCS_MASTER_CONFIG_TWO_MASK;
  wire [7:0] master_config_one_write = reg_wdata & master_config_one_wmask;
  wire [7:0] master_config_two_write = reg_wdata & master_config_two_wmask;
  wire master_config_one_wr = reg_wr && hit_master_config_one;
  wire hard_clear = rst || !pin_reset_sync_n;
  wire bank_wr = reg_wr && hit_bank && !soft_reset;
  wire master_config_two_wr = reg_wr && hit_master_config_two && !soft_reset;
  // struct images drop the unused bit positions of each register byte
  wire [7:0] master_config_one_rst_byte = `GCCS_RST_MASTER_CONFIG_ONE;
  wire [7:0] master_config_two_rst_byte = `GCCS_RST_MASTER_CONFIG_TWO;
  wire [6:0] master_config_one_rst_img = {master_config_one_rst_byte[7], master_config_one_rst_byte[5:0]};
  wire [5:0] master_config_two_rst_img = {master_config_two_rst_byte[6:4], master_config_two_rst_byte[2:0]};
  wire [6:0] master_config_one_normal = {master_config_one_write[7], master_config_one_write[5:0]};
  wire [6:0] master_config_one_held = {master_config_one_write[7], master_config_one_rst_img[5:0]};
  wire [6:0] master_config_one_idle = {master_config_one.soft_reset, master_config_one_rst_img[5:0]};
  wire [5:0] master_config_two_fields = {master_config_two_write[6:4], master_config_two_write[2:0]};
  logic next_bank_sel;
  gccs_pkg::gccs_master_config_one_s next_master_config_one;
  gccs_pkg::gccs_master_config_two_s next_master_config_two;

  assign next_bank_sel = soft_reset ? `GCCS_RST_BANK :
                         bank_wr ? reg_wdata[`GCCS_BIT_BANK] : bank_sel;
  assign next_master_config_two = soft_reset ? gccs_pkg::gccs_master_config_two_s'(master_config_two_rst_img) :
                     master_config_two_wr ? gccs_pkg::gccs_master_config_two_s'(master_config_two_fields) : master_config_two;

  // only the soft reset bit may be rewritten while it holds everything
  always_comb begin
    next_master_config_one = master_config_one;
    if (soft_reset) begin
      next_master_config_one = gccs_pkg::gccs_master_config_one_s'(master_config_one_wr ? master_config_one_held : master_config_one_idle);
    end else if (master_config_one_wr) begin
      next_master_config_one = gccs_pkg::gccs_master_config_one_s'(master_config_one_normal);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (hard_clear) begin
      bank_sel <= `GCCS_RST_BANK;
    end else begin
      bank_sel <= next_bank_sel;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (hard_clear) begin
      master_config_one <= gccs_pkg::gccs_master_config_one_s'(master_config_one_rst_img);
    end else begin
      master_config_one <= next_master_config_one;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (hard_clear) begin
      master_config_two <= gccs_pkg::gccs_master_config_two_s'(master_config_two_rst_img);
    end else begin
      master_config_two <= next_master_config_two;
    end
  end

  assign master_config_one_byte = {master_config_one.soft_reset, 1'b0, master_config_one.master_clock_from_input_one,
                      master_config_one.master_clock_from_osc_pin, master_config_one.ring_osc_disable,
                      master_config_one.clock_doubler_enable, master_config_one.osc_pin_mode};
  assign master_config_two_byte = {1'b0, master_config_two.ext_switch_source, master_config_two.auto_increment_disable,
                      1'b0, master_config_two.master_clock_range};

  // bank bit reads as zero; software must shadow it
  always_comb begin
    next_rdata = 8'h00;
    if (hit_bank) begin
      next_rdata = 8'h00;
    end else if (hit_master_config_one) begin
      next_rdata = master_config_one_byte;
    end else if (hit_master_config_two) begin
      next_rdata = master_config_two_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  assign eeprom_bank_active = bank_sel;
  assign device_in_reset = soft_reset || !pin_reset_sync_n;

  // host sequencing of selects, ring disable and doubler is trusted
  assign master_clock_source = master_config_one.master_clock_from_input_one ? gccs_pkg::GCCS_CLK_IC1 :
                               master_config_one.master_clock_from_osc_pin ? gccs_pkg::GCCS_CLK_OSC :
                               gccs_pkg::GCCS_CLK_RING;
  assign ring_osc_power = !master_config_one.ring_osc_disable;
  assign doubler_power = master_config_one.clock_doubler_enable;

  wire [1:0] pin_mode = master_config_one.osc_pin_mode;
  logic pin_in_en;
  logic pin_out_en;
  logic pin_single;
  always_comb begin
    pin_in_en = 1'b0;
    pin_out_en = 1'b0;
    pin_single = 1'b0;
    case (pin_mode)
      gccs_pkg::GCCS_PIN_XTAL: begin
        pin_in_en = 1'b1;
        pin_out_en = 1'b1;
      end
      gccs_pkg::GCCS_PIN_EXT: begin
        // the second pin floats, so only the input stays powered
        pin_in_en = 1'b1;
        pin_single = 1'b1;
      end
      // off and the unused code both leave the pins powered down
      default: begin
        pin_in_en = 1'b0;
      end
    endcase
  end
  assign osc_input_pin_enable = pin_in_en;
  assign osc_output_pin_enable = pin_out_en;
  assign osc_single_ended = pin_single;

  assign ext_switch_source = master_config_two.ext_switch_source;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sw
      assign gpio_switch_select[gi] = master_config_two.ext_switch_source == 2'(gi);
    end
  endgenerate

  assign auto_increment_disable = master_config_two.auto_increment_disable;
  assign addr_advance = !master_config_two.auto_increment_disable;
  assign master_clock_range = master_config_two.master_clock_range;
endmodule : gccs_global_config
`default_nettype wire

// ### test/gccs_cfg_asserts.sv
// Purpose: port assertions of the config block
// Assumes: bound to gccs_global_config
// Notes: field checks skip soft reset writes
`timescale 1ns/10ps
`default_nettype none
module gccs_cfg_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [10:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic eeprom_bank_active,
  input wire logic device_in_reset,
  input var gccs_pkg::gccs_clk_src_e master_clock_source,
  input wire logic [1:0] ext_switch_source,
  input wire logic [3:0] gpio_switch_select,
  input wire logic auto_increment_disable,
  input wire logic addr_advance
);
  logic wr1;
  assign wr1 = reg_wr && reg_addr == 11'h009 && !eeprom_bank_active;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_src_select: assert property (wr1 && !device_in_reset && !reg_wdata[7] |=>
    master_clock_source == ($past(reg_wdata[5]) ? 3'h4 : $past(reg_wdata[4]) ? 3'h2 : 3'h1))
    else $error("bad source");
  chk_srst_hold: assert property (wr1 && reg_wdata[7] |=> device_in_reset)
    else $error("no hold");
  chk_srst_ring: assert property (device_in_reset |=> master_clock_source == 3'h1)
    else $error("not ring");
  chk_bank_write: assert property (reg_wr && reg_addr == 11'h000 && !device_in_reset |=>
    eeprom_bank_active == $past(reg_wdata[0])) else $error("bank bit");
  chk_bank_hides: assert property (reg_rd && eeprom_bank_active && reg_addr == 11'h009
    |=> reg_rdata == 8'h00) else $error("bank read");
  chk_unused_zero: assert property (reg_rd && reg_addr == 11'h00a |=>
    !reg_rdata[7] && !reg_rdata[3]) else $error("unused bits");
  chk_gpio_decode: assert property (gpio_switch_select == 4'h1 << ext_switch_source)
    else $error("gpio");
  chk_addr_adv: assert property (addr_advance != auto_increment_disable)
    else $error("advance");
  cover property (wr1 && reg_wdata[7]);
  cover property (reg_rd && eeprom_bank_active);
  cover property (reg_wr && reg_addr == 11'h00a);
endmodule : gccs_cfg_asserts
bind gccs_global_config gccs_cfg_asserts chk_u (.*);
`default_nettype wire

// ### test/gccs_host.sv
// Purpose: host processor model on the register port
// Assumes: one byte per strobe
// Notes: released lines show inverted values
`timescale 1ns/10ps
`default_nettype none
module gccs_host #(parameter int SETTLE = 20) (
  input wire logic sys_clk,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [10:0] reg_addr = 11'h000,
  output logic [7:0] reg_wdata = 8'h00
);
  task automatic xfer(input logic rd, input logic [10:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= rd;
    reg_wr <= !rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(negedge sys_clk);
  endtask : xfer
  // selects cleared first so the clock switch settles before reset
  task automatic soft_reset();
    xfer(1'b0, 11'h009, 8'h00);
    xfer(1'b0, 11'h009, 8'h80);
  endtask : soft_reset
  // crystal settle time shortened to SETTLE cycles
  task automatic osc_up();
    xfer(1'b0, 11'h009, 8'h01);
    repeat (SETTLE) @(posedge sys_clk);
    xfer(1'b0, 11'h009, 8'h15);
  endtask : osc_up
endmodule : gccs_host
`default_nettype wire

// ### test/gccs_global_config_bench.sv
// Purpose: self-checking bench of the config block
// Assumes: host model drives the register port
// Notes: straps held across a soft reset
`timescale 1ns/10ps
`default_nettype none
module gccs_global_config_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_low_n = 1'b1;
  logic [1:0] strap_pins = 2'h0;
  logic reg_wr, reg_rd, eeprom_bank_active, device_in_reset, ring_osc_power, doubler_power;
  logic osc_input_pin_enable, osc_output_pin_enable, osc_single_ended, auto_increment_disable;
  logic addr_advance;
  logic [10:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] strap_defaults, ext_switch_source;
  logic [3:0] gpio_switch_select;
  logic [2:0] master_clock_range;
  gccs_pkg::gccs_clk_src_e master_clock_source;
  int err_total = 0;
  int num_checks = 0;
  always #5 sys_clk = ~sys_clk;
  gccs_host host_u (.*);
  gccs_global_config dut_u (.*);
  task automatic ck(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : ck
  task automatic t_clock();
    ck("src", 8'(master_clock_source), 8'h01);
    for (int m = 0; m < 4; m++) begin
      host_u.xfer(1'b0, 11'h009, 8'(m));
      ck("pins", 8'({osc_input_pin_enable, osc_output_pin_enable}), 8'(m == 1 ? 3 : m == 2 ? 2 : 0));
      ck("single", 8'(osc_single_ended), 8'(m == 2));
    end
    host_u.osc_up();
    ck("dbl", 8'({master_clock_source, doubler_power}), 8'h05);
    host_u.xfer(1'b0, 11'h009, 8'h38);
    ck("ic1", 8'({master_clock_source, ring_osc_power}), 8'h08);
    host_u.xfer(1'b1, 11'h009, 8'h00);
    ck("master_config_one", reg_rdata, 8'h38);
    $display("clock test end");
  endtask : t_clock
  task automatic t_master_config_two();
    for (int k = 0; k < 4; k++) begin
      host_u.xfer(1'b0, 11'h00a, {1'b1, 2'(k), 5'h1d});
      ck("gpio", 8'(gpio_switch_select), 8'(4'h1 << k));
      host_u.xfer(1'b1, 11'h00a, 8'h00);
      ck("master_config_two", reg_rdata, {1'b0, 2'(k), 5'h15});
    end
    ck("inc", 8'({addr_advance, master_clock_range}), 8'h05);
    host_u.xfer(1'b0, 11'h000, 8'h01);
    host_u.xfer(1'b1, 11'h009, 8'h00);
    ck("bank", {eeprom_bank_active, reg_rdata[6:0]}, 8'h80);
    host_u.xfer(1'b0, 11'h000, 8'h00);
    $display("register test end");
  endtask : t_master_config_two
  task automatic t_reset();
    @(posedge sys_clk);
    strap_pins <= 2'h2;
    reset_pin_low_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    strap_pins <= 2'h1;
    reset_pin_low_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    host_u.xfer(1'b0, 11'h00a, 8'h60);
    host_u.soft_reset();
    ck("hold", 8'({device_in_reset, strap_defaults, master_clock_source}), 8'h31);
    host_u.xfer(1'b1, 11'h00a, 8'h00);
    ck("master_config_two", reg_rdata, 8'h00);
    host_u.xfer(1'b0, 11'h009, 8'h00);
    ck("run", 8'(device_in_reset), 8'h00);
    $display("reset test end");
  endtask : t_reset
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_clock();
    t_master_config_two();
    t_reset();
    report_and_stop();
  end
endmodule : gccs_global_config_bench
`default_nettype wire
